// [src/trim_programmer.sv]
// supply-pulse decoder, trim registers, fuse control and status port
// How it works
// (R1) trim set only by supply pulse train
// (R2) registers rewritable until device lock
// (R3) output follows provisional code at once
// (R4) lock fuse blocks all later programming
// (R5) release threshold is operate minus hysteresis
// (R6) thirty-one equal threshold steps
// (R7) five-bit code, one bitfield per bit
// (R8) hold level changes nothing
// (R9) each mid pulse advances address counter
// (R10) short high separates, long high blows fuse
// (R11) supply near zero clears registers, counter
// (R12) programmer sends one sequence per set bit
// (R13) programmer keeps supply up between sequences
// (R14) permanent equals provisional plus long pulse
// (R15) key: high, mid, high enables addressing
// (R16) address equals mid pulses after key
// (R17) lock bit sits at address thirty-two
// (R18) unset bitfields evaluate as zero
// (R19) level acts only after stable samples
// (R20) effective code is fuses or provisional bits
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module trim_programmer #(
    parameter int LONG_CYCLES = trim_prog_pkg::LONG_PULSE_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [1:0] supply_class,
    input wire logic [trim_prog_pkg::FIELD_W-1:0] fuse_sense,
    input wire logic [7:0] field,
    input wire trim_prog_pkg::reg_req_t bus_req,
    output logic [31:0] rd_data,
    output logic [trim_prog_pkg::FIELD_W-1:0] fuse_blow,
    output logic switch_on
);
    import trim_prog_pkg::*;

    localparam logic [HIGH_CNT_W-1:0] LONG_LAST = HIGH_CNT_W'(LONG_CYCLES - 1);

    level_t lvl;
    level_t lvl_prev;
    seq_state_t state;
    logic [3:0] samples;
    logic [FIELD_W-1:0] fuse_s1;
    logic [FIELD_W-1:0] fuse_q;
    logic [FIELD_W-1:0] prov;
    logic [5:0] addr_cnt;
    logic [HIGH_CNT_W-1:0] high_cnt;
    logic [CODE_W-1:0] eff_code;
    logic locked;
    logic rise_mid;
    logic rise_high;
    logic fall_high;
    logic high_short;

    level_filter u_filter (
        .core_clk(core_clk),
        .resetn(resetn),
        .level_raw(supply_class),
        .samples(samples),
        .level(lvl)
    );

    switch_comparator u_cmp (
        .core_clk(core_clk),
        .resetn(resetn),
        .code(eff_code),
        .field(field),
        .switch_on(switch_on)
    );

    // fuse sense lines settle slowly after power-up
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fuse_s1 <= '0;
            fuse_q <= '0;
        end else begin
            fuse_s1 <= fuse_sense;
            fuse_q <= fuse_s1;
        end
    end

    assign locked = fuse_q[LOCK_BIT]; // R4 R17

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lvl_prev <= LVL_CLEAR;
        end else begin
            lvl_prev <= lvl;
        end
    end

    assign rise_mid = lvl == LVL_COUNT && lvl_prev != LVL_COUNT; // R9
    assign rise_high = lvl == LVL_SEP && lvl_prev != LVL_SEP;
    assign fall_high = lvl != LVL_SEP && lvl_prev == LVL_SEP;
    assign high_short = high_cnt < LONG_LAST; // R10

    // pulse width is judged on the filtered level, so filter delay cancels
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            high_cnt <= '0;
        end else if (lvl != LVL_SEP) begin
            high_cnt <= '0;
        end else if (high_cnt != LONG_LAST) begin
            high_cnt <= high_cnt + HIGH_CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= S_IDLE;
        end else if (lvl == LVL_CLEAR || locked) begin
            state <= S_IDLE; // R11 R4
        end else begin
            case (state)
                S_IDLE: begin
                    if (fall_high && high_short) begin
                        state <= S_KEY1; // R15
                    end
                end
                S_KEY1: begin
                    if (rise_mid) begin
                        state <= S_KEY2; // R15
                    end else if (rise_high) begin
                        state <= S_IDLE;
                    end
                end
                S_KEY2: begin
                    if (fall_high) begin
                        state <= high_short ? S_ADDR : S_IDLE; // R15
                    end else if (rise_mid) begin
                        state <= S_IDLE;
                    end
                end
                S_ADDR: begin
                    if (rise_high) begin
                        state <= (addr_cnt != 6'h00) ? S_SET : S_IDLE;
                    end
                end
                S_SET: begin
                    if (fall_high) begin
                        state <= S_IDLE; // R14
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // counter restarts only on clear or when the key's last high falls, so stray mids are harmless
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            addr_cnt <= 6'h00;
        end else if (lvl == LVL_CLEAR) begin
            addr_cnt <= 6'h00; // R11
        end else if (state == S_KEY2 && fall_high) begin
            addr_cnt <= 6'h00; // R16
        end else if (state == S_ADDR && rise_mid && addr_cnt != ADDR_MAX) begin
            addr_cnt <= addr_cnt + 6'h01; // R9 R16
        end
    end

    // counted value is ORed in, so a decimal try and single-bit sets agree
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prov <= '0;
        end else if (lvl == LVL_CLEAR) begin
            prov <= '0; // R11 R2
        end else if (!locked && state == S_ADDR && rise_high && addr_cnt != 6'h00) begin
            prov <= prov | addr_cnt; // R1 R7 R17
        end
    end

    // fuse current flows only while the long separator level lasts
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fuse_blow <= '0;
        end else if (locked || lvl != LVL_SEP || state != S_SET) begin
            fuse_blow <= '0; // R4
        end else if (high_cnt == LONG_LAST) begin
            fuse_blow <= addr_cnt; // R10 R14 R17
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            eff_code <= '0;
        end else begin
            eff_code <= fuse_q[CODE_W-1:0] | prov[CODE_W-1:0]; // R20 R18 R3
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            samples <= CFG_SAMP_RESET;
        end else if (bus_req.wr && bus_req.addr == REG_CONFIG) begin
            samples <= bus_req.wdata[CFG_SAMP_LSB +: 4]; // R19
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 32'h0000_0000;
        end else begin
            rd_data <= 32'h0000_0000;
            if (bus_req.rd) begin
                case (bus_req.addr)
                    REG_STATUS: begin
                        rd_data[STAT_PROV_LSB +: FIELD_W] <= prov;
                        rd_data[STAT_FUSE_LSB +: FIELD_W] <= fuse_q;
                        rd_data[STAT_LOCK_BIT] <= locked;
                        rd_data[STAT_STATE_LSB +: 5] <= state;
                    end
                    REG_CODE: begin
                        rd_data[CODE_EFF_LSB +: CODE_W] <= eff_code;
                        rd_data[CODE_ADDR_LSB +: 6] <= addr_cnt;
                        rd_data[CODE_SW_BIT] <= switch_on;
                    end
                    REG_CONFIG: begin
                        rd_data[CFG_SAMP_LSB +: 4] <= samples;
                    end
                    default: begin
                        rd_data <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    sequence key_high_s;
        state == S_KEY2 && fall_high && high_short;
    endsequence

    sequence addr_set_s;
        state == S_ADDR && rise_high && addr_cnt != 6'h00 && !locked && lvl != LVL_CLEAR;
    endsequence

    clear_wipes_a: assert property (lvl == LVL_CLEAR |=> prov == '0 && addr_cnt == 6'h00) // R11
        else $error("clear level did not wipe trim state");

    hold_keeps_a: assert property ( // R8
        lvl == LVL_HOLD && lvl_prev == LVL_HOLD |=> $stable(prov) && $stable(addr_cnt))
        else $error("hold level changed trim state");

    mid_counts_a: assert property ( // R9
        state == S_ADDR && rise_mid && addr_cnt != ADDR_MAX && lvl != LVL_CLEAR
        |=> addr_cnt == $past(addr_cnt) + 6'h01)
        else $error("mid pulse did not advance address");

    key_enter_a: assert property ( // R15
        $rose(state == S_ADDR) |-> $past(state) == S_KEY2)
        else $error("addressing entered without key");

    key_done_a: assert property (key_high_s and lvl != LVL_CLEAR and !locked // R16
        |=> state == S_ADDR && addr_cnt == 6'h00)
        else $error("key did not open addressing at zero");

    bits_set_a: assert property (addr_set_s |=> (prov & $past(addr_cnt)) == $past(addr_cnt)) // R16
        else $error("addressed bitfield not set");

    lock_ignores_a: assert property (locked |=> state == S_IDLE && fuse_blow == '0) // R4
        else $error("programming accepted while locked");

    blow_long_a: assert property ( // R10
        $rose(fuse_blow != '0) |-> $past(state) == S_SET && $past(high_cnt) == LONG_LAST)
        else $error("fuse blown without long pulse");

    code_or_a: assert property ( // R20
        ##1 eff_code == ($past(fuse_q[CODE_W-1:0]) | $past(prov[CODE_W-1:0])))
        else $error("effective code not fuse or provisional");

    lock_freezes_a: assert property (locked && lvl != LVL_CLEAR |=> $stable(prov)) // R4 R2
        else $error("provisional bits changed while locked");

    short_sep_a: assert property (fall_high && high_short |-> fuse_blow == '0) // R10
        else $error("short separator pulse drove a fuse");

    blow_addr_a: assert property ( // R14 R17
        fuse_blow != '0 |-> $past(state) == S_SET && fuse_blow == $past(addr_cnt))
        else $error("fuse drive not at addressed bitfield");

    clear_idles_a: assert property (lvl == LVL_CLEAR |=> state == S_IDLE) // R11
        else $error("clear level left a sequence open");

    key_open_a: assert property ( // R15
        $rose(state == S_KEY1) |-> $past(fall_high) && $past(high_short))
        else $error("key started without a short separator");

    set_from_addr_a: assert property ( // R16
        $rose(state == S_SET) |-> $past(state) == S_ADDR && $past(rise_high) && addr_cnt != 6'h00)
        else $error("set step entered without an address");

    mid_only_addr_a: assert property ( // R9
        state != S_ADDR && state != S_KEY2 && lvl != LVL_CLEAR |=> $stable(addr_cnt))
        else $error("address counter moved outside addressing");

endmodule
`default_nettype wire

// [inc/trim_prog_pkg.sv]
// shared constants and types of the supply-pulse trim programmer
package trim_prog_pkg;

    localparam int CLK_MHZ = 50;
    localparam int LONG_PULSE_US = 100;
    localparam int LONG_PULSE_CYC = LONG_PULSE_US * CLK_MHZ;
    localparam int HIGH_CNT_W = 13;

    localparam int CODE_W = 5;
    localparam int FIELD_W = 6;
    localparam logic [5:0] LOCK_ADDR = 6'h20;
    localparam int LOCK_BIT = 5;
    localparam logic [5:0] ADDR_MAX = 6'h3f;

    localparam logic [7:0] THR_MIN = 8'h20;
    localparam logic [7:0] THR_STEP = 8'h04;
    localparam logic [7:0] THR_HYS = 8'h08;

    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CODE = 8'h04;
    localparam logic [7:0] REG_CONFIG = 8'h08;
    localparam int STAT_PROV_LSB = 0;
    localparam int STAT_FUSE_LSB = 6;
    localparam int STAT_LOCK_BIT = 12;
    localparam int STAT_STATE_LSB = 13;
    localparam int CODE_EFF_LSB = 0;
    localparam int CODE_ADDR_LSB = 8;
    localparam int CODE_SW_BIT = 16;
    localparam int CFG_SAMP_LSB = 0;
    localparam logic [3:0] CFG_SAMP_RESET = 4'h4;

    typedef enum logic [1:0] {
        LVL_CLEAR = 2'h0,
        LVL_HOLD = 2'h1,
        LVL_COUNT = 2'h2,
        LVL_SEP = 2'h3
    } level_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_KEY1 = 5'h02,
        S_KEY2 = 5'h04,
        S_ADDR = 5'h08,
        S_SET = 5'h10
    } seq_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    function automatic logic [7:0] thr_of(input logic [CODE_W-1:0] code);
        thr_of = THR_MIN + (8'(code) * THR_STEP);
    endfunction

endpackage

// [src/level_filter.sv]
// supply level class synchroniser and stability filter
`timescale 1ns/10ps
`default_nettype none
module level_filter (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [1:0] level_raw,
    input wire logic [3:0] samples,
    output trim_prog_pkg::level_t level
);
    import trim_prog_pkg::*;

    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] cand;
    logic [3:0] stable_cnt;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
        end else begin
            sync1 <= level_raw;
            sync2 <= sync1;
        end
    end

    // comparator chatter on a slow ramp must not look like a pulse
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cand <= 2'h0;
            stable_cnt <= 4'h0;
        end else if (sync2 != cand) begin
            cand <= sync2;
            stable_cnt <= 4'h0;
        end else if (stable_cnt != 4'hf) begin
            stable_cnt <= stable_cnt + 4'h1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            level <= LVL_CLEAR;
        end else if (stable_cnt >= samples) begin
            level <= level_t'(cand); // R19
        end
    end

    stable_only_a: assert property (@(posedge core_clk) disable iff (!resetn) // R19
        $changed(level) |-> $past(stable_cnt) >= $past(samples) && level == $past(cand))
        else $error("level class changed before it was stable");

endmodule
`default_nettype wire

// [src/switch_comparator.sv]
// operate and release threshold comparison with fixed hysteresis
`timescale 1ns/10ps
`default_nettype none
module switch_comparator (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [trim_prog_pkg::CODE_W-1:0] code,
    input wire logic [7:0] field,
    output logic switch_on
);
    import trim_prog_pkg::*;

    logic [7:0] operate_threshold;
    logic [7:0] release_threshold;

    // one step per code value, 31 steps from the minimum
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            operate_threshold <= THR_MIN;
        end else begin
            operate_threshold <= thr_of(code); // R6
        end
    end

    assign release_threshold = operate_threshold - THR_HYS; // R5

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            switch_on <= 1'b0;
        end else if (!switch_on && field >= operate_threshold) begin
            switch_on <= 1'b1; // R3
        end else if (switch_on && field < release_threshold) begin
            switch_on <= 1'b0; // R5
        end
    end

    op_step_a: assert property (@(posedge core_clk) disable iff (!resetn) // R6
        ##1 operate_threshold == thr_of($past(code)))
        else $error("operate threshold not at code step");

    hys_hold_a: assert property (@(posedge core_clk) disable iff (!resetn) // R5
        switch_on && field >= operate_threshold - THR_HYS |=> switch_on)
        else $error("output released inside hysteresis band");

endmodule
`default_nettype wire

// [test/supply_programmer_model.sv]
// behavioural external programmer on the supply pin and the fuse array it blows
`timescale 1ns/10ps
`default_nettype none
module supply_programmer_model (
    input wire logic core_clk,
    input wire logic [trim_prog_pkg::FIELD_W-1:0] fuse_blow,
    output logic [1:0] supply_class,
    output logic [trim_prog_pkg::FIELD_W-1:0] fuse_sense
);
    import trim_prog_pkg::*;
    logic [3:0] blow_cnt [FIELD_W];
    initial begin
        supply_class = 2'h0;
        fuse_sense = '0;
        for (int i = 0; i < FIELD_W; i++) begin
            blow_cnt[i] = 4'h0;
        end
    end
    // a fuse needs several cycles of drive, so a glitch cannot blow it
    always @(posedge core_clk) begin
        for (int i = 0; i < FIELD_W; i++) begin
            blow_cnt[i] <= !fuse_blow[i] ? 4'h0 : (blow_cnt[i] == 4'hf ? 4'hf : blow_cnt[i] + 4'h1);
            if (blow_cnt[i] == 4'h8) begin
                fuse_sense[i] <= 1'b1;
            end
        end
    end
    // supply class held for n cycles, changed right after an edge
    task automatic level(input logic [1:0] c, input int n);
        @(posedge core_clk);
        supply_class <= c;
        repeat (n - 1) @(posedge core_clk);
    endtask
    // key, address count, set pulse; a long set pulse blows the addressed fuse
    task automatic send_seq(input int n, input bit blow);
        level(LVL_SEP, 20);
        level(LVL_HOLD, 20);
        level(LVL_COUNT, 20);
        level(LVL_HOLD, 20);
        level(LVL_SEP, 20);
        level(LVL_HOLD, 20);
        for (int i = 0; i < n; i++) begin
            level(LVL_COUNT, 20);
            level(LVL_HOLD, 20);
        end
        level(LVL_SEP, blow ? 100 : 20);
        level(LVL_HOLD, 30);
    endtask
endmodule
`default_nettype wire

// [test/supply_pulse_trim_programmer_bench.sv]
// self-checking bench of the supply-pulse trim programmer
`timescale 1ns/10ps
`default_nettype none
module supply_pulse_trim_programmer_bench;
    import trim_prog_pkg::*;
    logic core_clk;
    logic resetn;
    logic [7:0] field;
    reg_req_t req;
    logic [31:0] rd_data;
    logic [FIELD_W-1:0] fuse_blow;
    logic [FIELD_W-1:0] fuse_sense;
    logic [FIELD_W-1:0] blow_seen;
    logic blow_clr;
    logic [1:0] supply_class;
    logic switch_on;
    logic [31:0] d;
    logic [4:0] n;
    logic [4:0] m;
    int err_total;
    int cmp_count;
    int seed;
    // short long-pulse count keeps the run brief; still well above short pulses
    trim_programmer #(.LONG_CYCLES(50)) DUT (
        .core_clk(core_clk),
        .resetn(resetn),
        .supply_class(supply_class),
        .fuse_sense(fuse_sense),
        .field(field),
        .bus_req(req),
        .rd_data(rd_data),
        .fuse_blow(fuse_blow),
        .switch_on(switch_on)
    );
    supply_programmer_model prog (
        .core_clk(core_clk),
        .fuse_blow(fuse_blow),
        .supply_class(supply_class),
        .fuse_sense(fuse_sense)
    );
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // one process owns the capture, the test only requests a clear
    always @(posedge core_clk) begin
        if (blow_clr) begin
            blow_seen <= '0;
        end else if (fuse_blow !== '0) begin
            blow_seen <= fuse_blow;
        end
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 v = rd_data;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        req.addr <= a;
        req.wdata <= v;
        req.wr <= 1'b1;
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask
    function automatic logic [31:0] exp_status(input logic [5:0] p, input logic [5:0] f);
        exp_status = 32'(p) | (32'(f) << STAT_FUSE_LSB) | (32'(f[LOCK_BIT]) << STAT_LOCK_BIT);
        exp_status = exp_status | (32'h1 << STAT_STATE_LSB);
    endfunction
    task automatic check_code(input logic [4:0] eff, input logic [5:0] addr);
        reg_read(REG_CODE, d);
        check("effective code", 32'(eff), 32'(d[CODE_EFF_LSB +: CODE_W]));
        check("address counter", 32'(addr), 32'(d[CODE_ADDR_LSB +: FIELD_W]));
    endtask
    task automatic put_field(input logic [7:0] v, input logic exp, input string what);
        @(posedge core_clk);
        field <= v;
        repeat (6) @(posedge core_clk);
        #1 check(what, 32'(exp), 32'(switch_on));
    endtask
    // thresholds worked out from the code, never from the design's function
    task automatic check_switch(input logic [4:0] code);
        logic [7:0] op;
        op = THR_MIN + 8'(code) * THR_STEP;
        put_field(op + 8'h1 + 8'($random(seed) & 3), 1'b1, "switch above operate");
        put_field(op - 8'h1, 1'b1, "switch inside hysteresis");
        put_field(op - THR_HYS - 8'h1, 1'b0, "switch below release");
        put_field(op - 8'h1, 1'b0, "switch stays released");
    endtask
    task automatic wipe();
        prog.level(LVL_CLEAR, 20);
        prog.level(LVL_HOLD, 40);
    endtask
    initial begin
        // roughly five times the expected run
        #1_000_000;
        err_total++;
        $display("watchdog expired");
        conclude();
    end
    initial begin
        seed = 91639;
        err_total = 0;
        cmp_count = 0;
        resetn = 1'b0;
        field = 8'h00;
        req = '0;
        blow_clr = 1'b0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        reg_read(REG_STATUS, d);
        check("status at reset", exp_status(6'h00, 6'h00), d);
        reg_read(REG_CONFIG, d);
        check("config at reset", 32'(CFG_SAMP_RESET), d);
        reg_write(8'h0c, 32'hffffffff);
        reg_write(REG_CODE, 32'hffffffff);
        reg_read(8'h0c, d);
        check("unmapped read", 32'h0, d);
        check_code(5'h00, 6'h00);
        reg_write(REG_CONFIG, 32'h5);
        reg_read(REG_CONFIG, d);
        check("config written", 32'h5, d);
        $display("test registers done");
        wipe();
        repeat (3) begin
            n = 5'($unsigned($random(seed)) % 31 + 1);
            m = 5'($unsigned($random(seed)) % 31 + 1);
            prog.send_seq(int'(n), 1'b0);
            check_code(n, 6'(n));
            check_switch(n);
            prog.send_seq(int'(m), 1'b0);
            check_code(n | m, 6'(m));
            wipe();
            check_code(5'h00, 6'h00);
        end
        $display("test provisional done");
        prog.send_seq(3, 1'b0);
        prog.level(LVL_HOLD, 200);
        check_code(5'h03, 6'h03);
        prog.send_seq(0, 1'b0);
        check_code(5'h03, 6'h00);
        for (int i = 0; i < 3; i++) begin
            prog.level(LVL_SEP, 20);
            prog.level(LVL_HOLD, 20);
            prog.level(LVL_COUNT, 20);
            prog.level(LVL_HOLD, 20);
            prog.level(LVL_COUNT, 20);
            prog.level(LVL_HOLD, 20);
        end
        prog.level(LVL_SEP, 20);
        prog.level(LVL_HOLD, 30);
        reg_read(REG_CODE, d);
        check("code after broken key", 32'h3, 32'(d[CODE_EFF_LSB +: CODE_W]));
        wipe();
        $display("test key and hold done");
        blow_clr <= 1'b1;
        @(posedge core_clk);
        blow_clr <= 1'b0;
        prog.send_seq(4, 1'b1);
        check("blow mask", 32'h4, 32'(blow_seen));
        wipe();
        check_code(5'h04, 6'h00);
        prog.send_seq(2, 1'b0);
        check_code(5'h06, 6'h02);
        wipe();
        prog.send_seq(32, 1'b1);
        check("lock blow mask", 32'h20, 32'(blow_seen));
        wipe();
        reg_read(REG_STATUS, d);
        check("status when locked", exp_status(6'h00, 6'h24), d);
        blow_clr <= 1'b1;
        @(posedge core_clk);
        blow_clr <= 1'b0;
        prog.send_seq(1, 1'b0);
        prog.send_seq(3, 1'b1);
        check_code(5'h04, 6'h00);
        check("blow while locked", 32'h0, 32'(blow_seen));
        check("fuses while locked", 32'h24, 32'(fuse_sense));
        $display("test permanent and lock done");
        conclude();
    end
endmodule
`default_nettype wire
